/* File: core/clkctl_pkg.sv */
package clkctl_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned FAST_OSC_PERIOD_NS = 100;
	localparam int unsigned SLOW_OSC_PERIOD_NS = 31250;
	localparam int unsigned FAST_OSC_CYCLES = FAST_OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned SLOW_OSC_CYCLES = SLOW_OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [2:0] FAST_CNT_MAX = 3'(FAST_OSC_CYCLES - 1);
	localparam logic [10:0] SLOW_CNT_MAX = 11'(SLOW_OSC_CYCLES - 1);
	// Fast oscillator ticks without an oscillator edge that declare the source missing
	localparam logic [3:0] MISS_LIMIT = 4'h8;
	localparam int unsigned NUM_PERIPH = 8;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] PLL_CTL_OFF = 8'h00;
	localparam logic [7:0] PLL_MULT_OFF = 8'h04;
	localparam logic [7:0] PLL_STAT_OFF = 8'h08;
	localparam logic [7:0] SYS_DIV_OFF = 8'h0c;
	localparam logic [7:0] SS_DIV_OFF = 8'h10;
	localparam logic [7:0] ANA_CTL_OFF = 8'h14;
	localparam logic [7:0] CTRL_REQ_OFF = 8'h18;
	localparam logic [7:0] MST_RECLAIM_OFF = 8'h1c;
	localparam logic [7:0] RUN_GATE_OFF = 8'h20;
	localparam logic [7:0] SLP_GATE_OFF = 8'h24;
	localparam logic [7:0] DS_GATE_OFF = 8'h28;
	localparam logic [7:0] RUN_CFG_OFF = 8'h2c;
	localparam logic [7:0] DEV_CFG_OFF = 8'h30;
	localparam logic [7:0] DS_CFG_OFF = 8'h34;
	localparam logic [7:0] SYS_CTRL_OFF = 8'h38;
	localparam logic [7:0] CLPM_STAT_OFF = 8'h3c;

	////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int unsigned PLL_EN_BIT = 0;
	localparam int unsigned OWN_REQ_BIT = 0;
	localparam int unsigned ANA_SRC_BIT = 4;
	localparam int unsigned ACG_BIT = 0;
	localparam int unsigned SS_SRC_BIT = 1;
	localparam int unsigned CAN_SEL_LSB = 2;
	localparam int unsigned DS_DIV_LSB = 4;
	localparam int unsigned SOE_BIT = 1;
	localparam int unsigned DEEP_SEL_BIT = 2;
	localparam logic [7:0] DEV_CFG_RST = 8'hff;
	localparam logic [7:0] GATE_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Encodings
	localparam logic [1:0] MODE_RUN = 2'h0;
	localparam logic [1:0] MODE_SLEEP = 2'h1;
	localparam logic [1:0] MODE_DEEP = 2'h2;
	localparam logic [1:0] SRC_OSC = 2'h0;
	localparam logic [1:0] SRC_PLL = 2'h1;
	localparam logic [1:0] SRC_FAST = 2'h2;
	localparam logic [1:0] SRC_DEEP = 2'h3;
	localparam logic [1:0] CAN_SEL_SS = 2'h0;
	localparam logic [1:0] CAN_SEL_OSC = 2'h1;
	localparam logic [1:0] CAN_SEL_EXT = 2'h2;
	localparam logic [1:0] DS_SRC_SLOW = 2'h0;
	localparam logic [1:0] DS_SRC_FAST = 2'h1;

	typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_DEEP, ST_ISR_SLEEP, ST_ISR_DEEP} lp_state_t;

	typedef struct packed {
		logic sys;
		logic ss;
		logic ana;
		logic can;
		logic wdog;
		logic usb;
		logic cpu;
		logic ctrl;
		logic shared;
		logic [NUM_PERIPH-1:0] periph;
	} clk_out_t;

	typedef struct packed {
		logic main_pll_on;
		logic usb_pll_on;
		logic osc_power;
		logic clock_fail;
		logic [1:0] mode;
	} lp_status_t;

	typedef struct packed {
		logic pulse;
		logic [2:0] cnt;
	} div_t;

	// Whole state of the clock and low-power controller
	typedef struct packed {
		logic pll_en;
		logic [6:0] pll_mult;
		logic [2:0] sys_div;
		logic [2:0] ss_div;
		logic [2:0] ana_div;
		logic ana_src_osc;
		logic owner_ctrl;
		logic [7:0] run_gate;
		logic [7:0] slp_gate;
		logic [7:0] ds_gate;
		logic auto_gating_select;
		logic ss_src_osc;
		logic [1:0] can_sel;
		logic [7:0] dev_cfg;
		logic [1:0] ds_src;
		logic [2:0] ds_div;
		logic soe;
		logic deep_sel;
		logic [7:0] clpm;
		logic osc_s1;
		logic osc_s2;
		logic osc_s3;
		logic ext_s1;
		logic ext_s2;
		logic ext_s3;
		logic [2:0] fast_cnt;
		logic [10:0] slow_cnt;
		logic [3:0] miss_cnt;
		logic fail;
		logic [2:0] sys_cnt;
		logic [1:0] sys_sel;
		logic [2:0] ss_cnt;
		logic [1:0] ss_sel;
		logic [2:0] ds_cnt;
		logic [2:0] ana_cnt;
		lp_state_t fsm;
		clk_out_t clk;
		lp_status_t stat;
		logic [31:0] rdata;
	} state_t;

endpackage : clkctl_pkg

/* File: core/master_clock_lowpower_ctrl.sv */
`timescale 1ns/1ns
module master_clock_lowpower_ctrl
	import clkctl_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	input wire logic [7:0] CTRL_ADDR_I,
	input wire logic [31:0] CTRL_WDATA_I,
	input wire logic CTRL_WR_I,
	input wire logic PLL_TICK_I,
	input wire logic USB_PLL_TICK_I,
	input wire logic OSC_PIN_I,
	input wire logic XCLK_PIN_I,
	input wire logic WFI_I,
	input wire logic IRQ_I,
	input wire logic ISR_DONE_I,
	output clk_out_t CLOCKS_O,
	output lp_status_t STATUS_O,
	output logic CLOCK_FAIL_O
);

	state_t s_q;
	state_t s_d;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Divide a tick stream by sel+1; restart drops the count so the first
	// pulse after a source change is a full period of the new source
	function automatic div_t div_step(input logic [2:0] cnt, input logic [2:0] sel, input logic tick,
			input logic restart);
		div_t r;
		r.pulse = 1'b0;
		r.cnt = cnt;
		if (restart) begin
			r.cnt = 3'h0;
		end else if (tick) begin
			if (cnt >= sel) begin
				r.cnt = 3'h0;
				r.pulse = 1'b1;
			end else begin
				r.cnt = cnt + 3'h1;
			end
		end
		return r;
	endfunction : div_step

	function automatic logic [1:0] lp_mode(input lp_state_t st);
		case (st)
			ST_SLEEP: lp_mode = MODE_SLEEP;
			ST_DEEP: lp_mode = MODE_DEEP;
			default: lp_mode = MODE_RUN;
		endcase
	endfunction : lp_mode

	// Writes to the three PLL registers, shared by whichever port owns them
	function automatic state_t pll_write(input state_t s, input logic [7:0] addr, input logic [31:0] data);
		state_t r;
		r = s;
		case (addr)
			PLL_CTL_OFF: r.pll_en = data[PLL_EN_BIT];
			PLL_MULT_OFF: r.pll_mult = data[6:0];
			SYS_DIV_OFF: r.sys_div = data[2:0];
			default: r = s;
		endcase
		return r;
	endfunction : pll_write

	////////////////////////////////////////////////////////////////////////
	// Next state

	logic osc_tick, ext_tick, fast_tick, slow_tick, is_deep;
	logic ds_tick, sys_src_tick, sys_pulse, ss_src_tick, ss_pulse;
	logic [7:0] gate_sel;
	div_t dv_sys, dv_ss, dv_ds, dv_ana;
	logic [NUM_PERIPH-1:0] periph_d;

	// Peripheral gates: setting applies only where the peripheral is configured
	generate
		for (genvar g = 0; g < NUM_PERIPH; g++) begin : g_gate
			assign periph_d[g] = ss_pulse & gate_sel[g] & s_q.dev_cfg[g];
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		// Edge detectors read only the second and third flops
		osc_tick = s_q.osc_s2 & ~s_q.osc_s3;
		ext_tick = s_q.ext_s2 & ~s_q.ext_s3;
		fast_tick = (s_q.fast_cnt == FAST_CNT_MAX);
		slow_tick = (s_q.slow_cnt == SLOW_CNT_MAX);
		is_deep = (s_q.fsm == ST_DEEP);
		s_d.osc_s1 = OSC_PIN_I;
		s_d.osc_s2 = s_q.osc_s1;
		s_d.osc_s3 = s_q.osc_s2;
		s_d.ext_s1 = XCLK_PIN_I;
		s_d.ext_s2 = s_q.ext_s1;
		s_d.ext_s3 = s_q.ext_s2;
		s_d.fast_cnt = fast_tick ? 3'h0 : s_q.fast_cnt + 3'h1;
		s_d.slow_cnt = slow_tick ? 11'h000 : s_q.slow_cnt + 11'h001;

		// Missing-clock watch on the oscillator, timed by the fast oscillator, idle while the oscillator is off
		if (osc_tick || !s_q.stat.osc_power) begin
			s_d.miss_cnt = 4'h0;
		end else if (fast_tick && s_q.miss_cnt != MISS_LIMIT) begin
			s_d.miss_cnt = s_q.miss_cnt + 4'h1;
		end
		if (s_d.miss_cnt == MISS_LIMIT) begin
			s_d.fail = 1'b1;
		end

		// System clock
		if (s_q.fail) begin
			s_d.sys_sel = SRC_FAST;
		end else if (s_q.pll_en) begin
			s_d.sys_sel = SRC_PLL;
		end else begin
			s_d.sys_sel = SRC_OSC;
		end
		case (s_q.sys_sel)
			SRC_PLL: sys_src_tick = PLL_TICK_I;
			SRC_FAST: sys_src_tick = fast_tick;
			default: sys_src_tick = osc_tick;
		endcase
		dv_sys = div_step(s_q.sys_cnt, s_q.sys_div, sys_src_tick, s_d.sys_sel != s_q.sys_sel);
		s_d.sys_cnt = dv_sys.cnt;
		if (s_q.sys_sel == SRC_FAST) begin
			sys_pulse = fast_tick & ~is_deep;
		end else begin
			sys_pulse = dv_sys.pulse & ~is_deep;
		end

		// Deep sleep source and its own divider
		case (s_q.ds_src)
			DS_SRC_SLOW: ds_tick = slow_tick;
			DS_SRC_FAST: ds_tick = fast_tick;
			default: ds_tick = osc_tick;
		endcase
		dv_ds = div_step(s_q.ds_cnt, s_q.ds_div, ds_tick, ~is_deep);
		s_d.ds_cnt = dv_ds.cnt;

		// Subsystem clock
		if (is_deep) begin
			s_d.ss_sel = SRC_DEEP;
		end else if (s_q.fail) begin
			s_d.ss_sel = SRC_FAST;
		end else if (s_q.ss_src_osc) begin
			s_d.ss_sel = SRC_OSC;
		end else begin
			s_d.ss_sel = SRC_PLL;
		end
		case (s_q.ss_sel)
			SRC_DEEP: ss_src_tick = dv_ds.pulse;
			SRC_FAST: ss_src_tick = fast_tick;
			SRC_OSC: ss_src_tick = osc_tick;
			default: ss_src_tick = sys_pulse;
		endcase
		dv_ss = div_step(s_q.ss_cnt, s_q.ss_div, ss_src_tick, s_d.ss_sel != s_q.ss_sel);
		s_d.ss_cnt = dv_ss.cnt;
		ss_pulse = dv_ss.pulse;

		// Analog clock
		dv_ana = div_step(s_q.ana_cnt, s_q.ana_div, s_q.ana_src_osc ? osc_tick : sys_pulse, s_q.fail | is_deep);
		s_d.ana_cnt = dv_ana.cnt;

		// Gating register in force; Sleep keeps the Run frequency
		if (s_q.auto_gating_select && s_q.fsm == ST_SLEEP) begin
			gate_sel = s_q.slp_gate;
		end else if (s_q.auto_gating_select && is_deep) begin
			gate_sel = s_q.ds_gate;
		end else begin
			gate_sel = s_q.run_gate;
		end

		s_d.clk.sys = sys_pulse;
		s_d.clk.ss = ss_pulse;
		s_d.clk.ana = ~is_deep & (s_q.fail ? fast_tick : dv_ana.pulse);
		case (s_q.can_sel)
			CAN_SEL_OSC: s_d.clk.can = osc_tick;
			CAN_SEL_EXT: s_d.clk.can = ext_tick;
			default: s_d.clk.can = ss_pulse;
		endcase
		s_d.clk.wdog = osc_tick;
		s_d.clk.usb = USB_PLL_TICK_I & ~is_deep;
		s_d.clk.cpu = ss_pulse & (lp_mode(s_q.fsm) == MODE_RUN);
		s_d.clk.ctrl = sys_pulse;
		s_d.clk.shared = sys_pulse;
		s_d.clk.periph = periph_d;

		// Low-power sequencing
		case (s_q.fsm)
			ST_RUN: begin
				if (WFI_I) begin
					s_d.fsm = s_q.deep_sel ? ST_DEEP : ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (IRQ_I) begin
					s_d.fsm = s_q.soe ? ST_ISR_SLEEP : ST_RUN;
				end
			end
			ST_DEEP: begin
				if (IRQ_I) begin
					s_d.fsm = s_q.soe ? ST_ISR_DEEP : ST_RUN;
				end
			end
			ST_ISR_SLEEP: begin
				if (ISR_DONE_I) begin
					s_d.fsm = s_q.soe ? ST_SLEEP : ST_RUN;
				end else if (WFI_I) begin
					s_d.fsm = s_q.deep_sel ? ST_DEEP : ST_SLEEP;
				end
			end
			ST_ISR_DEEP: begin
				if (ISR_DONE_I) begin
					s_d.fsm = s_q.soe ? ST_DEEP : ST_RUN;
				end else if (WFI_I) begin
					s_d.fsm = s_q.deep_sel ? ST_DEEP : ST_SLEEP;
				end
			end
			default: s_d.fsm = ST_RUN;
		endcase
		s_d.stat.mode = lp_mode(s_d.fsm);
		s_d.stat.main_pll_on = (s_d.fsm != ST_DEEP);
		s_d.stat.usb_pll_on = (s_d.fsm != ST_DEEP);
		s_d.stat.osc_power = !(s_d.fsm == ST_DEEP && (s_q.ds_src == DS_SRC_SLOW || s_q.ds_src == DS_SRC_FAST));
		s_d.stat.clock_fail = s_d.fail;

		// Control-port writes
		if (CTRL_WR_I) begin
			if (s_q.owner_ctrl) begin
				s_d = pll_write(s_d, CTRL_ADDR_I, CTRL_WDATA_I);
			end
			case (CTRL_ADDR_I)
				CTRL_REQ_OFF: s_d.owner_ctrl = s_d.owner_ctrl | CTRL_WDATA_I[OWN_REQ_BIT];
				ANA_CTL_OFF: begin
					s_d.ana_div = CTRL_WDATA_I[2:0];
					s_d.ana_src_osc = CTRL_WDATA_I[ANA_SRC_BIT];
				end
				CLPM_STAT_OFF: s_d.clpm = CTRL_WDATA_I[7:0];
				default: s_d.clpm = s_d.clpm;
			endcase
		end

		// Master-port writes; a reclaim beats a same-cycle control request
		if (WR_I) begin
			if (!s_q.owner_ctrl) begin
				s_d = pll_write(s_d, ADDR_I, WDATA_I);
			end
			case (ADDR_I)
				MST_RECLAIM_OFF: s_d.owner_ctrl = s_d.owner_ctrl & ~WDATA_I[OWN_REQ_BIT];
				SS_DIV_OFF: s_d.ss_div = WDATA_I[2:0];
				RUN_GATE_OFF: s_d.run_gate = WDATA_I[7:0];
				SLP_GATE_OFF: s_d.slp_gate = WDATA_I[7:0];
				DS_GATE_OFF: s_d.ds_gate = WDATA_I[7:0];
				RUN_CFG_OFF: begin
					s_d.auto_gating_select = WDATA_I[ACG_BIT];
					s_d.ss_src_osc = WDATA_I[SS_SRC_BIT];
					s_d.can_sel = WDATA_I[CAN_SEL_LSB+1:CAN_SEL_LSB];
				end
				DEV_CFG_OFF: s_d.dev_cfg = WDATA_I[7:0];
				DS_CFG_OFF: begin
					s_d.ds_src = WDATA_I[1:0];
					s_d.ds_div = WDATA_I[DS_DIV_LSB+2:DS_DIV_LSB];
				end
				SYS_CTRL_OFF: begin
					s_d.soe = WDATA_I[SOE_BIT];
					s_d.deep_sel = WDATA_I[DEEP_SEL_BIT];
				end
				default: s_d.owner_ctrl = s_d.owner_ctrl;
			endcase
		end

		// Read data stands for exactly one cycle
		s_d.rdata = 32'h0000_0000;
		if (RD_I) begin
			case (ADDR_I)
				PLL_CTL_OFF: s_d.rdata = {31'h0, s_q.pll_en};
				PLL_MULT_OFF: s_d.rdata = {25'h0, s_q.pll_mult};
				PLL_STAT_OFF: s_d.rdata = {27'h0, s_q.stat.main_pll_on, s_q.stat.mode, s_q.owner_ctrl, s_q.fail};
				SYS_DIV_OFF: s_d.rdata = {29'h0, s_q.sys_div};
				SS_DIV_OFF: s_d.rdata = {29'h0, s_q.ss_div};
				ANA_CTL_OFF: s_d.rdata = {27'h0, s_q.ana_src_osc, 1'b0, s_q.ana_div};
				CTRL_REQ_OFF: s_d.rdata = {31'h0, s_q.owner_ctrl};
				RUN_GATE_OFF: s_d.rdata = {24'h0, s_q.run_gate};
				SLP_GATE_OFF: s_d.rdata = {24'h0, s_q.slp_gate};
				DS_GATE_OFF: s_d.rdata = {24'h0, s_q.ds_gate};
				RUN_CFG_OFF: s_d.rdata = {28'h0, s_q.can_sel, s_q.ss_src_osc, s_q.auto_gating_select};
				DEV_CFG_OFF: s_d.rdata = {24'h0, s_q.dev_cfg};
				DS_CFG_OFF: s_d.rdata = {25'h0, s_q.ds_div, 2'h0, s_q.ds_src};
				SYS_CTRL_OFF: s_d.rdata = {29'h0, s_q.deep_sel, s_q.soe, 1'b0};
				CLPM_STAT_OFF: s_d.rdata = {24'h0, s_q.clpm};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			s_q <= '0;
			s_q.dev_cfg <= DEV_CFG_RST;
			s_q.run_gate <= GATE_RST;
			s_q.stat.main_pll_on <= 1'b1;
			s_q.stat.usb_pll_on <= 1'b1;
			s_q.stat.osc_power <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign RDATA_O = s_q.rdata;
	assign CLOCKS_O = s_q.clk;
	assign STATUS_O = s_q.stat;
	assign CLOCK_FAIL_O = s_q.fail;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);

	sequence seq_isr_sleep_done;
		s_q.fsm == ST_ISR_SLEEP && ISR_DONE_I && s_q.soe;
	endsequence

	sequence seq_low_wake;
		(s_q.fsm == ST_SLEEP || s_q.fsm == ST_DEEP) && IRQ_I && !s_q.soe;
	endsequence

	chk_bypass_source: assert property (
		(!s_q.fail && !s_q.pll_en && s_q.sys_sel == SRC_OSC && s_q.sys_div == 3'h0 && s_q.fsm != ST_DEEP
			&& osc_tick) |=> CLOCKS_O.sys)
		else $error("bypassed system clock missed an oscillator tick");
	chk_fail_substitute: assert property (
		(s_q.fail && s_q.sys_sel == SRC_FAST && s_q.fsm != ST_DEEP) |=> (CLOCKS_O.sys == $past(fast_tick)))
		else $error("system clock not replaced by fast oscillator");
	chk_fail_raise: assert property (
		(!s_q.fail && s_q.stat.osc_power && !osc_tick && fast_tick && s_q.miss_cnt == MISS_LIMIT - 4'h1)
			|=> CLOCK_FAIL_O ##1 CLOCK_FAIL_O)
		else $error("clock failure flag not raised and held");
	chk_owner_block: assert property (
		(s_q.owner_ctrl && WR_I && ADDR_I == PLL_CTL_OFF && !CTRL_WR_I) |=> $stable(s_q.pll_en))
		else $error("master wrote PLL register without ownership");
	chk_wfi_entry: assert property (
		(s_q.fsm == ST_RUN && WFI_I) |=> (STATUS_O.mode == ($past(s_q.deep_sel) ? MODE_DEEP : MODE_SLEEP)))
		else $error("wait-for-interrupt entered the wrong mode");
	chk_wake_run: assert property (
		seq_low_wake |=> (STATUS_O.mode == MODE_RUN) ##1 (CLOCKS_O.cpu == CLOCKS_O.ss))
		else $error("interrupt did not return to run");
	chk_cpu_gated: assert property (
		(lp_mode(s_q.fsm) != MODE_RUN) |=> !CLOCKS_O.cpu)
		else $error("processor clocked in low power");
	chk_periph_cfg: assert property (
		(CLOCKS_O.periph & ~$past(s_q.dev_cfg)) == 8'h00)
		else $error("unconfigured peripheral received a clock");
	chk_deep_off: assert property (
		(s_q.fsm == ST_DEEP && $past(s_q.fsm) == ST_DEEP) |-> (!CLOCKS_O.sys && !CLOCKS_O.usb && !CLOCKS_O.ana
			&& !STATUS_O.main_pll_on && !STATUS_O.usb_pll_on))
		else $error("deep sleep left a clock running");
	chk_osc_power: assert property (
		(s_q.fsm == ST_DEEP && (s_q.ds_src == DS_SRC_SLOW || s_q.ds_src == DS_SRC_FAST) && $stable(s_q.ds_src))
			|-> !STATUS_O.osc_power)
		else $error("oscillator powered with internal deep sleep source");
	chk_isr_return: assert property (
		seq_isr_sleep_done |=> s_q.fsm == ST_SLEEP)
		else $error("sleep-on-exit did not return to sleep");

endmodule : master_clock_lowpower_ctrl

/* File: testbench/clk_src_model.sv */
`timescale 1ns/1ns
module clk_src_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic pll_on_i,
	input wire logic usb_on_i,
	input wire logic osc_pwr_i,
	input wire logic osc_stop_i,
	output logic pll_tick_o,
	output logic usb_tick_o,
	output logic osc_pin_o,
	output logic xclk_pin_o
);
	logic [3:0] cnt_q;

	// PLL every 2 cycles, USB PLL every 4, oscillator period 4, external period 6
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 4'h0;
			pll_tick_o <= 1'b0;
			usb_tick_o <= 1'b0;
			osc_pin_o <= 1'b0;
			xclk_pin_o <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == 4'hb) ? 4'h0 : cnt_q + 4'h1;
			pll_tick_o <= pll_on_i & cnt_q[0];
			usb_tick_o <= usb_on_i & (cnt_q[1:0] == 2'h3);
			osc_pin_o <= osc_pwr_i & !osc_stop_i & cnt_q[1];
			xclk_pin_o <= (cnt_q % 4'h6) < 4'h3;
		end
	end
endmodule : clk_src_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top
	import clkctl_pkg::*;
;
	localparam int SYS = 8, SS = 7, ANA = 6, CAN = 5, WD = 4, USB = 3, CPU = 2, CTL = 1, SH = 0;
	logic clk, rst_n, wr, rd, cwr, wait_for_interrupt_instr, irq, isr_done, osc_stop;
	logic [7:0] addr, caddr;
	logic [31:0] wdata, cwdata, rdata, rv;
	logic pll_tick, usb_tick, osc_pin, xclk_pin, fail;
	clk_out_t clks;
	lp_status_t st;
	int bad_count, n_tests;
	int c[9];
	logic [7:0] pmask;

	master_clock_lowpower_ctrl i_master_clock_lowpower_ctrl (.CLOCK_I(clk), .RESET_N_I(rst_n),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.CTRL_ADDR_I(caddr), .CTRL_WDATA_I(cwdata), .CTRL_WR_I(cwr),
		.PLL_TICK_I(pll_tick), .USB_PLL_TICK_I(usb_tick), .OSC_PIN_I(osc_pin),
		.XCLK_PIN_I(xclk_pin), .WFI_I(wait_for_interrupt_instr), .IRQ_I(irq), .ISR_DONE_I(isr_done),
		.CLOCKS_O(clks), .STATUS_O(st), .CLOCK_FAIL_O(fail));

	clk_src_model i_clk_src_model (.clk_i(clk), .rst_n_i(rst_n), .pll_on_i(st.main_pll_on),
		.usb_on_i(st.usb_pll_on), .osc_pwr_i(st.osc_power), .osc_stop_i(osc_stop),
		.pll_tick_o(pll_tick), .usb_tick_o(usb_tick), .osc_pin_o(osc_pin), .xclk_pin_o(xclk_pin));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	task automatic check_val(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask : check_val

	// Pulse counts may differ by one from the window edges
	task automatic check_near(input string n, input int e, input int g);
		n_tests++;
		if (g < e - 1 || g > e + 1) begin
			$display("mismatch %s expected %0d seen %0d", n, e, g);
			bad_count++;
		end
	endtask : check_near

	task automatic chk_mode(input logic [1:0] m);
		check_val("mode", {30'h0, m}, {30'h0, st.mode});
	endtask : chk_mode

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	task automatic creg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		caddr <= a;
		cwdata <= d;
		cwr <= 1'b1;
		@(posedge clk);
		cwr <= 1'b0;
	endtask : creg

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check_val(n, e, rdata);
	endtask : rchk

	// Kind 0 wait-for-interrupt, 1 interrupt, 2 routine done
	task automatic strobe(input int k);
		@(posedge clk);
		wait_for_interrupt_instr <= (k == 0);
		irq <= (k == 1);
		isr_done <= (k == 2);
		@(posedge clk);
		{wait_for_interrupt_instr, irq, isr_done} <= 3'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask : strobe

	task automatic measure();
		for (int i = 0; i < 9; i++) c[i] = 0;
		pmask = 8'h00;
		repeat (240) begin
			@(posedge clk);
			#1;
			for (int i = 0; i < 9; i++) c[i] += int'(clks[8 + i]);
			pmask |= clks.periph;
		end
	endtask : measure

	////////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		{rst_n, wr, rd, cwr, wait_for_interrupt_instr, irq, isr_done, osc_stop} = 8'h00;
		{addr, caddr, wdata, cwdata} = 80'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		rchk("stat", PLL_STAT_OFF, 32'h00000010);
		rchk("devcfg", DEV_CFG_OFF, 32'h000000ff);
		rchk("unmapped", 8'h40, 32'h0);
		wreg(PLL_MULT_OFF, 32'h55);
		rchk("pllmult", PLL_MULT_OFF, 32'h55);
		wreg(CLPM_STAT_OFF, 32'h5);
		rchk("clpm", CLPM_STAT_OFF, 32'h0);
		wreg(RUN_CFG_OFF, 32'h8);
		wreg(DEV_CFG_OFF, 32'h33);
		wreg(RUN_GATE_OFF, 32'h0f);
		wreg(SLP_GATE_OFF, 32'hf0);
		wreg(DS_GATE_OFF, 32'h20);
		measure();
		check_near("sys", 60, c[SYS]);
		check_near("ss", 60, c[SS]);
		check_near("ana", 60, c[ANA]);
		check_near("wdog", 60, c[WD]);
		check_near("usb", 60, c[USB]);
		check_near("can", 40, c[CAN]);
		check_near("ctrl", 60, c[CTL]);
		check_near("shared", 60, c[SH]);
		check_val("pmask", 32'h03, {24'h0, pmask});
		creg(PLL_CTL_OFF, 32'h1);
		rchk("pllctl", PLL_CTL_OFF, 32'h0);
		creg(CTRL_REQ_OFF, 32'h1);
		rchk("stat", PLL_STAT_OFF, 32'h00000012);
		wreg(SYS_DIV_OFF, 32'h2);
		rchk("sysdiv", SYS_DIV_OFF, 32'h0);
		creg(PLL_CTL_OFF, 32'h1);
		creg(SYS_DIV_OFF, 32'h2);
		wreg(MST_RECLAIM_OFF, 32'h1);
		rchk("pllctl", PLL_CTL_OFF, 32'h1);
		rchk("stat", PLL_STAT_OFF, 32'h00000010);
		wreg(RUN_CFG_OFF, 32'h4);
		measure();
		check_near("sys", 40, c[SYS]);
		check_near("cpu", 40, c[CPU]);
		check_near("can", 60, c[CAN]);
		strobe(0);
		chk_mode(MODE_SLEEP);
		measure();
		check_val("cpu", 32'h0, c[CPU]);
		check_near("ss", 40, c[SS]);
		check_near("ctrl", 40, c[CTL]);
		check_val("pmask", 32'h03, {24'h0, pmask});
		strobe(1);
		chk_mode(MODE_RUN);
		wreg(RUN_CFG_OFF, 32'h9);
		strobe(0);
		measure();
		check_val("pmask", 32'h30, {24'h0, pmask});
		strobe(1);
		creg(CLPM_STAT_OFF, 32'h1);
		rchk("clpm", CLPM_STAT_OFF, 32'h1);
		wreg(SYS_CTRL_OFF, 32'h2);
		strobe(0);
		chk_mode(MODE_SLEEP);
		strobe(1);
		chk_mode(MODE_RUN);
		strobe(2);
		chk_mode(MODE_SLEEP);
		wreg(SYS_CTRL_OFF, 32'h0);
		strobe(1);
		chk_mode(MODE_RUN);
		wreg(RUN_CFG_OFF, 32'h0);
		wreg(DS_CFG_OFF, 32'h11);
		wreg(SYS_CTRL_OFF, 32'h6);
		strobe(0);
		chk_mode(MODE_DEEP);
		check_val("power", 32'h0, {29'h0, st.main_pll_on, st.usb_pll_on, st.osc_power});
		measure();
		check_val("off", 32'h0, c[CTL] + c[SH] + c[ANA] + c[USB] + c[CPU]);
		check_near("ss", 24, c[SS]);
		check_val("pmask", 32'h03, {24'h0, pmask});
		strobe(1);
		chk_mode(MODE_RUN);
		strobe(2);
		chk_mode(MODE_DEEP);
		wreg(SYS_CTRL_OFF, 32'h4);
		strobe(1);
		repeat (20) @(posedge clk);
		measure();
		chk_mode(MODE_RUN);
		check_near("cpu", 40, c[CPU]);
		check_near("can", 40, c[CAN]);
		wreg(RUN_CFG_OFF, 32'h2);
		wreg(SS_DIV_OFF, 32'h1);
		creg(ANA_CTL_OFF, 32'h11);
		wreg(ANA_CTL_OFF, 32'h0);
		rchk("anactl", ANA_CTL_OFF, 32'h11);
		rchk("ssdiv", SS_DIV_OFF, 32'h1);
		measure();
		check_near("ss", 30, c[SS]);
		check_near("can", 30, c[CAN]);
		check_near("ana", 30, c[ANA]);
		check_near("sys", 40, c[SYS]);
		wreg(SS_DIV_OFF, 32'h0);
		wreg(RUN_CFG_OFF, 32'h9);
		strobe(0);
		measure();
		check_val("pmask", 32'h20, {24'h0, pmask});
		strobe(1);
		repeat (20) @(posedge clk);
		wreg(DS_CFG_OFF, 32'h2);
		strobe(0);
		check_val("power", 32'h1, {29'h0, st.main_pll_on, st.usb_pll_on, st.osc_power});
		measure();
		check_near("ss", 60, c[SS]);
		strobe(1);
		wreg(DS_CFG_OFF, 32'h0);
		strobe(0);
		check_val("power", 32'h0, {29'h0, st.main_pll_on, st.usb_pll_on, st.osc_power});
		strobe(1);
		repeat (20) @(posedge clk);
		osc_stop <= 1'b1;
		for (i = 0; i < 200 && fail !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (fail !== 1'b1) begin
			bad_count++;
			print_verdict();
		end
		check_val("stfail", 32'h1, {31'h0, st.clock_fail});
		measure();
		check_near("sys", 48, c[SYS]);
		check_near("ss", 48, c[SS]);
		check_near("ana", 48, c[ANA]);
		print_verdict();
	end
endmodule : tb_top
